// >>> design/uis_pkg.sv
/*
 * Shared constants of the USB interface status and PHY control block:
 * register offsets, field positions, reset values and line symbols.
 * Assumes an 8-bit byte address on the register port, 32-bit data.
 */
package uis_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_HOLD  = 8'h20;
    localparam logic [7:0] OFS_PMASK = 8'h24;
    localparam logic [7:0] OFS_SOF   = 8'h28;
    localparam logic [7:0] OFS_PID   = 8'h2C;
    localparam logic [7:0] OFS_EP    = 8'h30;
    localparam logic [7:0] OFS_EPMSK = 8'h34;
    localparam logic [7:0] OFS_PWR   = 8'h38;
    localparam logic [7:0] OFS_PHY   = 8'h3C;
    localparam logic [7:0] OFS_IRQST = 8'h40;
    localparam logic [7:0] OFS_IRQMK = 8'h44;
    localparam logic [7:0] OFS_LINE  = 8'h48;
    // Field positions (low bit of each field).
    localparam int PM_A_LSB  = 0;
    localparam int PM_B_LSB  = 8;
    localparam int PM_C_LSB  = 16;
    localparam int SOF_HI    = 8;
    localparam int EP_VLD    = 4;
    localparam int PWR_VLD   = 8;
    localparam int PHY_PD    = 18;
    localparam int PHY_RSE0  = 13;
    localparam int PHY_RK    = 12;
    localparam int PHY_FLT   = 8;
    localparam int PHY_AUTO  = 7;
    localparam int PHY_CONF  = 4;
    // Flag bit indices and the flags that are pulses rather than levels.
    localparam int FL_TOKEN  = 6;
    localparam int FL_SE0    = 5;
    localparam int FL_K      = 4;
    localparam int FL_J      = 3;
    localparam int FL_CRC    = 2;
    localparam int FL_RXACT  = 1;
    localparam int FL_RXERR  = 0;
    localparam logic [6:0] FLAG_PULSE = 7'h44;
    localparam logic [31:0] RST_VAL   = 32'h0000_0000;
    // Full-speed line symbols on the two-bit line state.
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;
endpackage : uis_pkg

// >>> design/uis_filt_if.sv
/*
 * Carrier between the register block and its line state filter.
 * Assumes both ends sit on clk_sys.
 */
`timescale 1ns/10ps
interface uis_filt_if;
    logic [1:0] raw;
    logic [3:0] log2_len;
    logic [1:0] filt;
    modport ctrl (output raw, output log2_len, input filt);
    modport flt  (input raw, input log2_len, output filt);
endinterface : uis_filt_if

// >>> design/uis_line_filter.sv
/*
 * Line state filter: a change of the line state is passed on only after
 * it has stood unchanged for two to the power log2_len clocks.
 * Assumes raw is already synchronised to clk_sys.
 */
`timescale 1ns/10ps
module uis_line_filter #(
    parameter int CNT_W = 16
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    uis_filt_if.flt   fif
);
    logic [1:0]       cand;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit;

    // Fifteen is the largest length code, so the counter needs 16 bits.
    if (CNT_W < 16) begin : g_bad_width
        $error("uis_line_filter: CNT_W must be at least 16");
    end

    assign limit = (CNT_W'(1) << fif.log2_len) - CNT_W'(1);

    // Delay line changes.
    // A new candidate restarts the count, so glitches never reach filt.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cand     <= 2'h0;
            cnt      <= '0;
            fif.filt <= 2'h0;
        end else if (fif.raw != cand) begin
            cand <= fif.raw;
            cnt  <= '0;
        end else if (cand != fif.filt) begin
            if (cnt >= limit) begin
                fif.filt <= cand;
                cnt      <= '0;
            end else begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

    AST_FILT_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(fif.filt) |-> fif.filt == $past(cand) && $past(cnt) >= $past(limit))
        else $error("filtered line state moved before its delay ran out");
endmodule : uis_line_filter

// >>> design/uis_top.sv
/*
 * Upper register set of the USB interface module: signal flags, flag
 * event ports, frame counter, last PID and endpoint, endpoint marking,
 * power signalling word, PHY control and a small interrupt block.
 * Assumes PHY line pins arrive asynchronously; packet decode strobes
 * come from logic on clk_sys.
 */
// Chosen here: strobed register access.
// Function
// - Three ports high on any masked flag.
// - Writable 11-bit frame counter, reset zero.
// - Capture last received PID, read-only.
// - Keep last endpoint with valid bit.
// - Marked endpoints leave with bit four set.
// - Control bit disables both data pulldowns.
// - Auto-resume cause bits, cleared by zero.
// - Filter line changes by two-power clocks.
// - Auto resume, else software polls line.
// - Drive PHY configuration pins from field.
// - Power word: data and valid bit.
// - Flags follow tokens, symbols, CRC, receive.
// - Sticky flags hold until one written.
`timescale 1ns/10ps
module uis_top #(
    parameter int FLT_CNT_W = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic [1:0]  line_state,
    input  wire logic        rx_active,
    input  wire logic        rx_error,
    input  wire logic        token_ok,
    input  wire logic        crc16_fail,
    input  wire logic        pid_stb,
    input  wire logic [3:0]  pid_in,
    input  wire logic        ep_stb,
    input  wire logic [3:0]  ep_in,
    input  wire logic        sof_stb,
    input  wire logic [10:0] sof_in,
    input  wire logic        suspended,
    output logic             flag_event_port_a,
    output logic             flag_event_port_b,
    output logic             flag_event_port_c,
    output logic      [4:0]  rx_ep_out,
    output logic             rx_ep_stb,
    output logic             usb_data_port_low_pd_dis,
    output logic             usb_data_port_high_pd_dis,
    output logic      [2:0]  phy_config_pins,
    output logic      [7:0]  pwr_data,
    output logic             pwr_valid,
    output logic             resume_req,
    output logic             irq
);
    uis_filt_if fif ();

    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  pin_s;
    logic        rxact_d;
    logic        pkt_start;
    logic [6:0]  flags;
    logic [6:0]  next_flags;
    logic [6:0]  cond;
    logic [6:0]  flag_hold_select;
    logic [6:0]  flag_clr;
    logic [22:0] pmask;
    logic [22:0] next_pmask;
    logic [10:0] sof_cnt;
    logic [3:0]  pid_last;
    logic [3:0]  ep_last;
    logic        ep_valid;
    logic [15:0] ep_mark;
    logic        pd_dis;
    logic        res_se0;
    logic        res_k;
    logic [3:0]  flt_log2;
    logic        auto_res;
    logic [2:0]  conf;
    logic [1:0]  filt_d;
    logic        wake_se0;
    logic        wake_k;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_ev;
    logic        we_flags;
    logic        we_hold;
    logic        we_pmask;
    logic        we_sof;
    logic        we_epmsk;
    logic        we_pwr;
    logic        we_phy;
    logic        we_irqst;
    logic        we_irqmk;

    if (FLT_CNT_W < 16) begin : g_bad_cnt
        $error("uis_top: FLT_CNT_W must be at least 16");
    end

    // Write decode, one strobe per writable register.
    assign we_flags = wr_en && addr == uis_pkg::OFS_FLAGS;
    assign we_hold  = wr_en && addr == uis_pkg::OFS_HOLD;
    assign we_pmask = wr_en && addr == uis_pkg::OFS_PMASK;
    assign we_sof   = wr_en && addr == uis_pkg::OFS_SOF;
    assign we_epmsk = wr_en && addr == uis_pkg::OFS_EPMSK;
    assign we_pwr   = wr_en && addr == uis_pkg::OFS_PWR;
    assign we_phy   = wr_en && addr == uis_pkg::OFS_PHY;
    assign we_irqst = wr_en && addr == uis_pkg::OFS_IRQST;
    assign we_irqmk = wr_en && addr == uis_pkg::OFS_IRQMK;

    // Pin synchroniser; the settled copy moves only when stages 2 and 3
    // agree, which costs a cycle but rejects a single metastable sample.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
            pin_s <= 4'h0;
        end else begin
            sync1 <= {rx_error, rx_active, line_state};
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                pin_s <= sync3;
            end
        end
    end

    assign fif.raw      = pin_s[1:0];
    assign fif.log2_len = flt_log2;

    uis_line_filter #(
        .CNT_W (FLT_CNT_W)
    ) u_filter (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .fif     (fif)
    );

    // Start of a packet ends the life of non-sticky pulse flags.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxact_d <= 1'b0;
        end else begin
            rxact_d <= pin_s[2];
        end
    end
    assign pkt_start = pin_s[2] && !rxact_d;

    assign cond[uis_pkg::FL_TOKEN] = token_ok;
    assign cond[uis_pkg::FL_SE0]   = fif.filt == uis_pkg::LS_SE0;
    assign cond[uis_pkg::FL_K]     = fif.filt == uis_pkg::LS_K;
    assign cond[uis_pkg::FL_J]     = fif.filt == uis_pkg::LS_J;
    assign cond[uis_pkg::FL_CRC]   = crc16_fail;
    assign cond[uis_pkg::FL_RXACT] = pin_s[2];
    assign cond[uis_pkg::FL_RXERR] = pin_s[3];
    assign flag_clr = we_flags ? wr_data[6:0] : 7'h00;

    // Sticky or following flags.
    // A new event beats a clear in the same cycle.
    for (genvar i = 0; i < 7; i++) begin : g_flag
        assign next_flags[i] = cond[i]
            | (flags[i] & ~flag_clr[i] & flag_hold_select[i])
            | (flags[i] & ~flag_clr[i] & uis_pkg::FLAG_PULSE[i] & ~pkt_start);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 7'h00;
        end else begin
            flags <= next_flags;
        end
    end

    // Sticky selection per flag.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_hold_select <= 7'h00;
        end else if (we_hold) begin
            flag_hold_select <= wr_data[6:0];
        end
    end

    // Port masks keep only mapped bits.
    assign next_pmask = we_pmask ? (wr_data[22:0] & 23'h7F7F7F) : pmask;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pmask <= uis_pkg::RST_VAL[22:0];
        end else begin
            pmask <= next_pmask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_event_port_a <= 1'b0;
            flag_event_port_b <= 1'b0;
            flag_event_port_c <= 1'b0;
        end else begin
            flag_event_port_a <= |(next_flags & next_pmask[uis_pkg::PM_A_LSB +: 7]);
            flag_event_port_b <= |(next_flags & next_pmask[uis_pkg::PM_B_LSB +: 7]);
            flag_event_port_c <= |(next_flags & next_pmask[uis_pkg::PM_C_LSB +: 7]);
        end
    end

    // Frame counter load.
    // A frame from the wire wins over a software write in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sof_cnt <= 11'h000;
        end else if (sof_stb) begin
            sof_cnt <= sof_in;
        end else if (we_sof) begin
            sof_cnt <= wr_data[10:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pid_last <= 4'h0;
            ep_last  <= 4'h0;
            ep_valid <= 1'b0;
        end else begin
            if (pid_stb) begin
                pid_last <= pid_in;
            end
            if (ep_stb) begin
                ep_last  <= ep_in;
                ep_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ep_mark <= 16'h0000;
        end else if (we_epmsk) begin
            ep_mark <= wr_data[15:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_ep_out <= 5'h00;
            rx_ep_stb <= 1'b0;
        end else begin
            rx_ep_stb <= ep_stb;
            if (ep_stb) begin
                rx_ep_out <= {1'b0, ep_in} | (ep_mark[ep_in] ? 5'h10 : 5'h00);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_data  <= 8'h00;
            pwr_valid <= 1'b0;
        end else if (we_pwr) begin
            pwr_data  <= wr_data[7:0];
            pwr_valid <= wr_data[uis_pkg::PWR_VLD];
        end
    end

    // PHY control fields other than the cause bits.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_dis   <= 1'b0;
            flt_log2 <= 4'h0;
            auto_res <= 1'b0;
            conf     <= 3'h0;
        end else if (we_phy) begin
            pd_dis   <= wr_data[uis_pkg::PHY_PD];
            flt_log2 <= wr_data[uis_pkg::PHY_FLT +: 4];
            auto_res <= wr_data[uis_pkg::PHY_AUTO];
            conf     <= wr_data[uis_pkg::PHY_CONF +: 3];
        end
    end

    assign usb_data_port_low_pd_dis  = pd_dis;
    assign usb_data_port_high_pd_dis = pd_dis;
    assign phy_config_pins           = conf;

    // Automatic resume detect.
    // Only a fresh arrival of SE0 or K while suspended counts as a wake.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filt_d <= uis_pkg::LS_J;
        end else begin
            filt_d <= fif.filt;
        end
    end
    assign wake_se0 = auto_res && suspended && fif.filt == uis_pkg::LS_SE0
                      && filt_d != uis_pkg::LS_SE0;
    assign wake_k   = auto_res && suspended && fif.filt == uis_pkg::LS_K
                      && filt_d != uis_pkg::LS_K;

    // Resume cause bits.
    // Writing one leaves a bit alone; a wake beats a clearing write.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_se0    <= 1'b0;
            res_k      <= 1'b0;
            resume_req <= 1'b0;
        end else begin
            resume_req <= wake_se0 || wake_k;
            if (wake_se0) begin
                res_se0 <= 1'b1;
            end else if (we_phy && !wr_data[uis_pkg::PHY_RSE0]) begin
                res_se0 <= 1'b0;
            end
            if (wake_k) begin
                res_k <= 1'b1;
            end else if (we_phy && !wr_data[uis_pkg::PHY_RK]) begin
                res_k <= 1'b0;
            end
        end
    end

    // Interrupt status: token, CRC failure, automatic resume.
    assign irq_ev = {wake_se0 || wake_k, crc16_fail, token_ok};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_st   <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            irq_st <= irq_ev | (irq_st & ~(we_irqst ? wr_data[2:0] : 3'h0));
            if (we_irqmk) begin
                irq_mask <= wr_data[2:0];
            end
        end
    end
    assign irq = |(irq_st & irq_mask);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= uis_pkg::RST_VAL;
        end else if (rd_en) begin
            unique case (addr)
                uis_pkg::OFS_FLAGS: rd_data <= {25'h0, flags};
                uis_pkg::OFS_HOLD:  rd_data <= {25'h0, flag_hold_select};
                uis_pkg::OFS_PMASK: rd_data <= {9'h0, pmask};
                uis_pkg::OFS_SOF:   rd_data <= {21'h0, sof_cnt};
                uis_pkg::OFS_PID:   rd_data <= {28'h0, pid_last};
                uis_pkg::OFS_EP:    rd_data <= {27'h0, ep_valid, ep_last};
                uis_pkg::OFS_EPMSK: rd_data <= {16'h0, ep_mark};
                uis_pkg::OFS_PWR:   rd_data <= {23'h0, pwr_valid, pwr_data};
                uis_pkg::OFS_PHY:   rd_data <= {13'h0, pd_dis, 4'h0, res_se0,
                                                res_k, flt_log2, auto_res,
                                                conf, 4'h0};
                uis_pkg::OFS_IRQST: rd_data <= {29'h0, irq_st};
                uis_pkg::OFS_IRQMK: rd_data <= {29'h0, irq_mask};
                uis_pkg::OFS_LINE:  rd_data <= {30'h0, fif.filt};
                default:            rd_data <= 32'h0000_0000;
            endcase
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_wake_se0;
        auto_res && suspended ##1 auto_res && suspended && fif.filt == uis_pkg::LS_SE0
            && $past(fif.filt) != uis_pkg::LS_SE0;
    endsequence

    AST_PORT_A: assert property (
        flag_event_port_a == |(flags & pmask[6:0]))
        else $error("event port a does not match masked flags");
    AST_PORT_C: assert property (
        flag_event_port_c == |(flags & pmask[22:16]))
        else $error("event port c does not match masked flags");
    AST_SOF_WR: assert property (
        we_sof && !sof_stb |=> sof_cnt == $past(wr_data[10:0]))
        else $error("frame counter did not take the written value");
    AST_PID_CAP: assert property (
        pid_stb ##1 rd_en && addr == uis_pkg::OFS_PID && !pid_stb
        |=> rd_data[3:0] == $past(pid_in, 2) && rd_data[31:4] == 28'h0)
        else $error("PID read back differs from the captured PID");
    AST_EP_CAP: assert property (
        ep_stb |=> ep_valid && ep_last == $past(ep_in))
        else $error("endpoint not captured with valid bit");
    AST_EP_MARK: assert property (
        ep_stb |=> rx_ep_stb && rx_ep_out[3:0] == $past(ep_in)
        && rx_ep_out[4] == $past(ep_mark[ep_in]))
        else $error("receive port endpoint marking wrong");
    AST_PD_CONF: assert property (
        we_phy |=> usb_data_port_low_pd_dis == $past(wr_data[uis_pkg::PHY_PD])
        && usb_data_port_high_pd_dis == $past(wr_data[uis_pkg::PHY_PD]))
        else $error("pulldown disable outputs disagree with control");
    AST_RES_SE0: assert property (
        s_wake_se0 |=> res_se0 && resume_req)
        else $error("SE0 wake did not set its cause bit");
    AST_CONF_PINS: assert property (
        we_phy |=> phy_config_pins == $past(wr_data[6:4]))
        else $error("PHY configuration pins not driven from field");
    AST_PWR_WR: assert property (
        we_pwr |=> pwr_data == $past(wr_data[7:0]) && pwr_valid == $past(wr_data[8]))
        else $error("power signalling word not stored");
    AST_TOKEN: assert property (
        token_ok |=> flags[uis_pkg::FL_TOKEN])
        else $error("token flag not set after a token");
    AST_STICKY: assert property (
        flags[2] && flag_hold_select[2] && !we_flags |=> flags[2])
        else $error("sticky CRC flag lost without a clear");
    AST_UNMAPPED: assert property (
        rd_en && addr == 8'h4C |=> rd_data == 32'h0000_0000)
        else $error("unmapped read did not return zero");
endmodule : uis_top

// >>> bench/uis_phy_model.sv
/*
 * Model of the PHY line side seen by the status block.
 * Assumes the bench changes the line symbol only between packets.
 */
`timescale 1ns/10ps
module uis_phy_model (
    input  wire logic       clk_sys,
    output logic      [1:0] line_state,
    output logic            rx_active,
    output logic            rx_error
);
    // An idle full-speed bus shows J; receive lines stay quiet.
    initial begin
        line_state = uis_pkg::LS_J;
        rx_active  = 1'b0;
        rx_error   = 1'b0;
    end

    // Resume line symbols
    // The symbol moves just after an edge, as a pin would, never on it.
    task automatic set_line(input logic [1:0] sym);
        @(posedge clk_sys);
        line_state <= sym;
    endtask : set_line

    // Receive lines mark packet starts and errors; they move off the edge too.
    task automatic set_rx(input logic act, input logic err);
        @(posedge clk_sys);
        rx_active <= act;
        rx_error  <= err;
    endtask : set_rx
endmodule : uis_phy_model

// >>> bench/uis_top_tb_top.sv
/*
 * Self-checking bench for the USB status and PHY control block.
 * Assumes the design package and the PHY line model are compiled first.
 */
`timescale 1ns/10ps
module uis_top_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0, rd_en = 1'b0, token_ok = 1'b0, crc16_fail = 1'b0;
    logic        pid_stb = 1'b0, ep_stb = 1'b0, suspended = 1'b0, sof_stb = 1'b0;
    logic [3:0]  pid_in  = 4'h0, ep_in = 4'h0;
    logic [10:0] sof_in  = 11'h000;
    int          wakes   = 0;
    logic [31:0] rd_data;
    logic [1:0]  line_state;
    logic [4:0]  rx_ep_out;
    logic [2:0]  cfg;
    logic [7:0]  pwr_data;
    logic        rx_active, rx_error, pa, pb, pc, rx_ep_stb, pd_lo, pd_hi;
    logic        pwr_valid, resume_req, irq;
    int          err_count = 0, checks_done = 0;
    logic [31:0] ones_exp [7] = '{32'h007F7F7F, 32'h7FF, 32'h0, 32'h0, 32'hFFFF, 32'h1FF,
                                  32'h40FF0};

    always #25 clk_sys = ~clk_sys;

    // Wake pulses stand one cycle, so one look per cycle counts each once.
    always @(negedge clk_sys) begin
        if (resume_req === 1'b1) wakes++;
    end

    uis_phy_model phy (.clk_sys(clk_sys), .line_state(line_state),
        .rx_active(rx_active), .rx_error(rx_error));

    uis_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .line_state(line_state),
        .rx_active(rx_active), .rx_error(rx_error), .token_ok(token_ok),
        .crc16_fail(crc16_fail), .pid_stb(pid_stb), .pid_in(pid_in), .ep_stb(ep_stb),
        .ep_in(ep_in), .sof_stb(sof_stb), .sof_in(sof_in), .suspended(suspended),
        .flag_event_port_a(pa), .flag_event_port_b(pb), .flag_event_port_c(pc),
        .rx_ep_out(rx_ep_out), .rx_ep_stb(rx_ep_stb), .usb_data_port_low_pd_dis(pd_lo),
        .usb_data_port_high_pd_dis(pd_hi), .phy_config_pins(cfg), .pwr_data(pwr_data),
        .pwr_valid(pwr_valid), .resume_req(resume_req), .irq(irq));

    // Every compare funnels here so the counts stay honest.
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write strobe; a gap cycle follows so strobes never merge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so look there.
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(negedge clk_sys);
        chk($sformatf("reg %h", a), rd_data, exp);
    endtask : rdc

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Cut a hang short well past the few hundred cycles the tests need.
    initial begin
        #(50 * 4000);
        err_count++;
        summarize();
    end

    // Main sequence of register and line scenarios.
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rdc(uis_pkg::OFS_PMASK + 8'(4 * i), 32'h0);
        $display("reset values done");
        // All ones into the seven registers from PMASK to PHY: reserved and read-only bits must not stick.
        for (int i = 0; i < 7; i++) wr(uis_pkg::OFS_PMASK + 8'(4 * i), 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) rdc(uis_pkg::OFS_PMASK + 8'(4 * i), ones_exp[i]);
        rdc(8'h4C, 32'h0);
        chk("pins", {pd_lo, pd_hi, cfg, pwr_valid, pwr_data}, 14'h3FFF);
        chk("ports", {pa, pb, pc}, 3'b111);
        wr(uis_pkg::OFS_PHY, 32'h0);
        @(negedge clk_sys);
        chk("pins off", {pd_lo, pd_hi, cfg}, 5'h00);
        $display("register access done");
        // Token and CRC events reach only the ports whose masks pick them.
        wr(uis_pkg::OFS_PMASK, 32'h00010440);
        @(posedge clk_sys);
        token_ok <= 1'b1;
        crc16_fail <= 1'b1;
        @(posedge clk_sys);
        token_ok <= 1'b0;
        crc16_fail <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("ports ev", {pa, pb, pc}, 3'b110);
        rdc(uis_pkg::OFS_FLAGS, 32'h4C);
        wr(uis_pkg::OFS_FLAGS, 32'h44);
        rdc(uis_pkg::OFS_FLAGS, 32'h08);
        chk("ports clr", {pa, pb, pc}, 3'b000);
        // A sticky CRC flag outlives the next packet start; the token flag does not.
        wr(uis_pkg::OFS_HOLD, 32'h04);
        @(posedge clk_sys);
        token_ok <= 1'b1;
        crc16_fail <= 1'b1;
        @(posedge clk_sys);
        token_ok <= 1'b0;
        crc16_fail <= 1'b0;
        phy.set_rx(1'b1, 1'b1);
        repeat (8) @(posedge clk_sys);
        rdc(uis_pkg::OFS_FLAGS, 32'h0F);
        chk("ports rx", {pa, pb, pc}, 3'b011);
        phy.set_rx(1'b0, 1'b0);
        repeat (8) @(posedge clk_sys);
        wr(uis_pkg::OFS_FLAGS, 32'h04);
        rdc(uis_pkg::OFS_FLAGS, 32'h08);
        $display("flag events done");
        // Marked and unmarked endpoints, back to back.
        wr(uis_pkg::OFS_EPMSK, 32'h0008);
        // A frame number load and a PID read ride along with the endpoints.
        @(posedge clk_sys);
        pid_stb <= 1'b1;
        pid_in <= 4'hA;
        ep_stb <= 1'b1;
        ep_in <= 4'h3;
        sof_stb <= 1'b1;
        sof_in <= 11'h5A5;
        @(posedge clk_sys);
        pid_stb <= 1'b0;
        sof_stb <= 1'b0;
        ep_in <= 4'h4;
        addr <= uis_pkg::OFS_PID;
        rd_en <= 1'b1;
        @(negedge clk_sys);
        chk("ep mark", {rx_ep_stb, rx_ep_out}, 6'h33);
        @(posedge clk_sys);
        ep_stb <= 1'b0;
        rd_en <= 1'b0;
        @(negedge clk_sys);
        chk("ep plain", {rx_ep_stb, rx_ep_out}, 6'h24);
        chk("pid next", rd_data, 32'hA);
        rdc(uis_pkg::OFS_SOF, 32'h5A5);
        rdc(uis_pkg::OFS_PID, 32'hA);
        rdc(uis_pkg::OFS_EP, 32'h14);
        $display("endpoints done");
        // Without auto resume a K while suspended leaves the cause bits alone.
        wr(uis_pkg::OFS_PHY, 32'h400);
        suspended <= 1'b1;
        phy.set_line(uis_pkg::LS_K);
        repeat (6) @(posedge clk_sys);
        rdc(uis_pkg::OFS_LINE, 32'h1);
        repeat (25) @(posedge clk_sys);
        rdc(uis_pkg::OFS_LINE, 32'h2);
        rdc(uis_pkg::OFS_PHY, 32'h400);
        phy.set_line(uis_pkg::LS_J);
        repeat (30) @(posedge clk_sys);
        // Auto resume on K, then on SE0 with the interrupt masked.
        wr(uis_pkg::OFS_IRQMK, 32'h4);
        wr(uis_pkg::OFS_PHY, 32'h480);
        phy.set_line(uis_pkg::LS_K);
        repeat (30) @(posedge clk_sys);
        rdc(uis_pkg::OFS_PHY, 32'h1480);
        chk("irq on", irq, 1'b1);
        wr(uis_pkg::OFS_PHY, 32'h480);
        rdc(uis_pkg::OFS_PHY, 32'h480);
        wr(uis_pkg::OFS_IRQST, 32'h4);
        wr(uis_pkg::OFS_IRQMK, 32'h0);
        @(negedge clk_sys);
        chk("irq off", irq, 1'b0);
        phy.set_line(uis_pkg::LS_J);
        repeat (30) @(posedge clk_sys);
        phy.set_line(uis_pkg::LS_SE0);
        repeat (30) @(posedge clk_sys);
        rdc(uis_pkg::OFS_PHY, 32'h2480);
        // Token and CRC status from the flag tests were never cleared.
        rdc(uis_pkg::OFS_IRQST, 32'h7);
        chk("irq masked", irq, 1'b0);
        chk("wakes", wakes, 32'h2);
        $display("auto resume done");
        summarize();
    end
endmodule : uis_top_tb_top
